// file: design/ibtd_pkg.sv
// constants, codes and shared decode functions for the input bus decoder
// assumes a 128-bit multiplexed address/data input bus and an apb register port
package ibtd_pkg;

    localparam int TT_W    = 5;
    localparam int ID_W    = 3;
    localparam int ADDR_W  = 40;
    localparam int DATA_W  = 128;
    localparam int BE_W    = 16;
    localparam int COH_BIT = 2;

    // transaction type codes; coherent types carry bit 2
    localparam logic [4:0] TT_READ          = 5'h00;
    localparam logic [4:0] TT_READ_BS       = 5'h01;
    localparam logic [4:0] TT_WRITE         = 5'h02;
    localparam logic [4:0] TT_WRITE_BACK    = 5'h03;
    localparam logic [4:0] TT_READ_SHAR     = 5'h04;
    localparam logic [4:0] TT_READ_CURRENT  = 5'h05;
    localparam logic [4:0] TT_READ_PRIV     = 5'h06;
    localparam logic [4:0] TT_CLEAR_PRIV    = 5'h07;
    localparam logic [4:0] TT_FLUSH_BACK    = 5'h08;
    localparam logic [4:0] TT_C2C_WRITE     = 5'h09;
    localparam logic [4:0] TT_FLUSH         = 5'h0c;
    localparam logic [4:0] TT_PURGE         = 5'h0d;
    localparam logic [4:0] TT_PURGE_ALLOC   = 5'h0e;
    localparam logic [4:0] TT_SYNC          = 5'h0f;
    localparam logic [4:0] TT_BCAST_ERR     = 5'h10;
    localparam logic [4:0] TT_IO_READ       = 5'h12;
    localparam logic [4:0] TT_IO_WRITE      = 5'h13;
    localparam logic [4:0] TT_READ_PRIV_0LN = 5'h16;

    // dependent memory space window
    localparam logic [39:0] PDH_BASE = 40'hf0_0000_0000;
    localparam logic [39:0] PDH_TOP  = 40'hf1_0000_0000;

    // register map (byte addresses)
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_MEM_LIMIT = 12'h004;
    localparam logic [11:0] OFS_IO_BASE   = 12'h008;
    localparam logic [11:0] OFS_STATUS    = 12'h00c;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ID_LSB = 4;
    localparam int ST_CNT_LSB  = 16;

    // control reset: enabled, controller master id 4 (arbitrary)
    localparam logic [31:0] CTRL_RST      = 32'h0000_0041;
    localparam logic [31:0] MEM_LIMIT_RST = 32'h0100_0000;
    localparam logic [31:0] IO_BASE_RST   = 32'hf000_0000;

    // address bytes, most significant first
    function automatic logic [39:0] ibtd_addr_of(input logic [127:0] d);
        return {d[31:24], d[39:32], d[47:40], d[55:48], d[63:56]};
    endfunction

    function automatic logic ibtd_is_mem(input logic [4:0] t);
        return (t <= TT_C2C_WRITE) || (t == TT_FLUSH) || (t == TT_PURGE)
            || (t == TT_PURGE_ALLOC) || (t == TT_READ_PRIV_0LN);
    endfunction

    function automatic logic ibtd_in_pdh(input logic [39:0] a);
        return (a >= PDH_BASE) && (a < PDH_TOP);
    endfunction

endpackage

// file: design/ibtd_apb_regs.sv
// apb slave holding control, range limits and a status view
// assumes apb3 master on mclk; one wait-free access phase per transfer
module ibtd_apb_regs (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] status_val,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] ctrl_reg,
    output logic      [31:0] mem_limit_reg,
    output logic      [31:0] io_base_reg
);

    logic [31:0] prdata_next;
    logic        pready_next;
    logic        pslverr_next;
    logic [31:0] ctrl_next;
    logic [31:0] mem_limit_next;
    logic [31:0] io_base_next;
    logic        setup;
    logic        wr;
    logic        hit;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    always_comb begin
        setup          = psel & ~penable;
        wr             = psel & penable & pready_reg & pwrite;
        hit            = (paddr == ibtd_pkg::OFS_CTRL) || (paddr == ibtd_pkg::OFS_MEM_LIMIT)
                      || (paddr == ibtd_pkg::OFS_IO_BASE) || (paddr == ibtd_pkg::OFS_STATUS);
        pready_next    = setup;
        pslverr_next   = setup & ~hit;
        prdata_next    = 32'h0000_0000;
        if (setup && !pwrite) begin
            unique case (paddr)
                ibtd_pkg::OFS_CTRL:      prdata_next = ctrl_reg;
                ibtd_pkg::OFS_MEM_LIMIT: prdata_next = mem_limit_reg;
                ibtd_pkg::OFS_IO_BASE:   prdata_next = io_base_reg;
                ibtd_pkg::OFS_STATUS:    prdata_next = status_val;
                default:                 prdata_next = 32'h0000_0000;
            endcase
        end
        ctrl_next      = (wr && paddr == ibtd_pkg::OFS_CTRL) ? pwdata : ctrl_reg;
        mem_limit_next = (wr && paddr == ibtd_pkg::OFS_MEM_LIMIT) ? pwdata : mem_limit_reg;
        io_base_next   = (wr && paddr == ibtd_pkg::OFS_IO_BASE) ? pwdata : io_base_reg;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            ctrl_reg      <= ibtd_pkg::CTRL_RST;
            mem_limit_reg <= ibtd_pkg::MEM_LIMIT_RST;
            io_base_reg   <= ibtd_pkg::IO_BASE_RST;
        end else if (ce) begin
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            ctrl_reg      <= ctrl_next;
            mem_limit_reg <= mem_limit_next;
            io_base_reg   <= io_base_next;
        end
    end

endmodule // ibtd_apb_regs

// file: design/ibtd_err_check.sv
// range and parity checks, one stage behind the strobes
// assumes even address and control parity bits arrive with the address
module ibtd_err_check (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic         go,
    input  wire logic         in_addr_valid,
    input  wire logic         in_data_valid,
    input  wire logic [4:0]   bus_txn_type,
    input  wire logic [2:0]   in_master_id,
    input  wire logic [127:0] in_addr_data,
    input  wire logic         in_addr_parity,
    input  wire logic         in_ctrl_parity,
    input  wire logic [31:0]  mem_limit,
    input  wire logic [31:0]  io_base,
    output logic              err_stage_reg,
    output logic              mem_oor_stage_reg,
    output logic [3:0]        cause_reg
);

    logic [39:0] addr;
    logic        av_only;
    logic        is_io;
    logic [3:0]  cause_next;
    logic        err_next;
    logic        mem_oor_next;

    always_comb begin
        addr      = ibtd_pkg::ibtd_addr_of(in_addr_data);
        av_only   = go & in_addr_valid & ~in_data_valid;
        is_io     = (bus_txn_type == ibtd_pkg::TT_IO_READ)
                 || (bus_txn_type == ibtd_pkg::TT_IO_WRITE);
        cause_next[0] = av_only & (bus_txn_type == ibtd_pkg::TT_BCAST_ERR);
        cause_next[1] = av_only & ibtd_pkg::ibtd_is_mem(bus_txn_type)
                      & ~ibtd_pkg::ibtd_in_pdh(addr) & (addr >= {mem_limit, 8'h00});
        cause_next[2] = av_only & is_io & (addr < {io_base, 8'h00});
        cause_next[3] = av_only & ((^{addr, in_addr_parity})
                      | (^{bus_txn_type, in_master_id, in_ctrl_parity}));
        err_next      = |cause_next;
        mem_oor_next  = cause_next[1];
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            err_stage_reg     <= 1'b0;
            mem_oor_stage_reg <= 1'b0;
            cause_reg         <= 4'h0;
        end else if (ce) begin
            err_stage_reg     <= err_next;
            mem_oor_stage_reg <= mem_oor_next;
            cause_reg         <= err_next ? cause_next : cause_reg;
        end
    end

endmodule // ibtd_err_check

// file: design/ibtd_top.sv
// input bus transaction decoder: strobes toward i/o and memory controllers
// assumes bus inputs synchronous to mclk, one address cycle per transaction
module ibtd_top (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic         srst,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         in_addr_valid,
    input  wire logic         in_data_valid,
    input  wire logic [4:0]   bus_txn_type,
    input  wire logic [2:0]   in_master_id,
    input  wire logic [127:0] in_addr_data,
    input  wire logic [15:0]  in_byte_enable,
    input  wire logic         in_addr_parity,
    input  wire logic         in_ctrl_parity,
    output logic              io_read_strobe,
    output logic              io_write_strobe,
    output logic              ctrl_cache_copy_wr_strobe,
    output logic              ctrl_return_valid,
    output logic [127:0]      ret_data,
    output logic [15:0]       byte_parity,
    output logic [15:0]       byte_enable,
    output logic              flush_strobe,
    output logic              purge_strobe,
    output logic              purge_alloc_strobe,
    output logic              sync_strobe,
    output logic              coherent_strobe,
    output logic              byte_swap_strobe,
    output logic              zero_len_strobe,
    output logic              private_strobe,
    output logic              mem_read_strobe,
    output logic              dep_space_line_read_strobe,
    output logic              ctrl_mastered,
    output logic              error_strobe,
    output logic              mem_oor_strobe
);

    ////////////////////////////////////////////////////////////////////////////////
    // registers and checks

    logic [31:0] ctrl_reg;
    logic [31:0] mem_limit_reg;
    logic [31:0] io_base_reg;
    logic [31:0] status_val;
    logic        err_stage;
    logic        mem_oor_stage;
    logic [3:0]  cause;
    logic [15:0] err_cnt_reg;
    logic [15:0] err_cnt_next;
    logic        go;
    logic [2:0]  ioc_id;

    assign go         = ctrl_reg[ibtd_pkg::CTRL_EN_BIT] & ~srst;
    assign ioc_id     = ctrl_reg[ibtd_pkg::CTRL_ID_LSB +: 3];
    assign status_val = {err_cnt_reg, 12'h000, cause};

    ibtd_apb_regs u_regs (
        .mclk          (mclk),
        .rstn          (rstn),
        .ce            (ce),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .status_val    (status_val),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .ctrl_reg      (ctrl_reg),
        .mem_limit_reg (mem_limit_reg),
        .io_base_reg   (io_base_reg)
    );

    ibtd_err_check u_err (
        .mclk              (mclk),
        .rstn              (rstn),
        .ce                (ce),
        .go                (go),
        .in_addr_valid     (in_addr_valid),
        .in_data_valid     (in_data_valid),
        .bus_txn_type      (bus_txn_type),
        .in_master_id      (in_master_id),
        .in_addr_data      (in_addr_data),
        .in_addr_parity    (in_addr_parity),
        .in_ctrl_parity    (in_ctrl_parity),
        .mem_limit         (mem_limit_reg),
        .io_base           (io_base_reg),
        .err_stage_reg     (err_stage),
        .mem_oor_stage_reg (mem_oor_stage),
        .cause_reg         (cause)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // strobe decode

    logic [39:0]  addr;
    logic         av_only;
    logic         path_err;
    logic         pdh;
    logic [4:0]   tt;
    logic [16:0]  stb_next;
    logic [16:0]  stb_reg;
    logic [127:0] ret_data_next;
    logic [15:0]  par_next;
    logic [15:0]  be_next;

    always_comb begin
        addr     = ibtd_pkg::ibtd_addr_of(in_addr_data);
        tt       = bus_txn_type;
        av_only  = go & in_addr_valid & ~in_data_valid;
        path_err = in_addr_valid & in_data_valid;
        pdh      = ibtd_pkg::ibtd_in_pdh(addr);
        // strobes from raw address, no check wait; error and range strobes from the check stage
        stb_next[0]  = av_only & (tt == ibtd_pkg::TT_IO_READ);
        stb_next[1]  = av_only & (tt == ibtd_pkg::TT_IO_WRITE);
        stb_next[2]  = av_only & (tt == ibtd_pkg::TT_C2C_WRITE) & (in_master_id == ioc_id);
        stb_next[3]  = go & in_data_valid & (in_master_id == ioc_id);
        stb_next[4]  = av_only & (tt == ibtd_pkg::TT_FLUSH);
        stb_next[5]  = av_only & (tt == ibtd_pkg::TT_PURGE);
        stb_next[6]  = av_only & (tt == ibtd_pkg::TT_PURGE_ALLOC);
        stb_next[7]  = av_only & (tt == ibtd_pkg::TT_SYNC);
        stb_next[8]  = av_only & tt[ibtd_pkg::COH_BIT];
        stb_next[9]  = av_only & (tt == ibtd_pkg::TT_READ_BS);
        stb_next[10] = av_only & (tt == ibtd_pkg::TT_READ_PRIV_0LN);
        stb_next[11] = av_only & ((tt == ibtd_pkg::TT_READ_PRIV)
                     | (tt == ibtd_pkg::TT_READ_PRIV_0LN) | (tt == ibtd_pkg::TT_CLEAR_PRIV));
        stb_next[12] = av_only & ~pdh & ((tt == ibtd_pkg::TT_READ) | (tt == ibtd_pkg::TT_READ_BS)
                     | (tt == ibtd_pkg::TT_READ_SHAR) | (tt == ibtd_pkg::TT_READ_CURRENT)
                     | (tt == ibtd_pkg::TT_READ_PRIV) | (tt == ibtd_pkg::TT_CLEAR_PRIV));
        stb_next[13] = av_only & pdh & ((tt == ibtd_pkg::TT_READ) | (tt == ibtd_pkg::TT_READ_BS));
        stb_next[14] = av_only & (in_master_id == ioc_id);
        stb_next[15] = go & err_stage;
        stb_next[16] = go & mem_oor_stage;
        ret_data_next = in_data_valid ? in_addr_data : ret_data;
        for (int i = 0; i < 16; i++) begin
            par_next[i] = path_err | (^in_addr_data[8*i +: 8]);
        end
        be_next      = (stb_next[0] | stb_next[1]) ? in_byte_enable : 16'h0000;
        err_cnt_next = stb_next[15] ? err_cnt_reg + 16'h0001 : err_cnt_reg;
    end

    // registered strobes, cleared by asynchronous reset rstn
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stb_reg     <= 17'h00000;
            ret_data    <= 128'h0;
            byte_parity <= 16'h0000;
            byte_enable <= 16'h0000;
            err_cnt_reg <= 16'h0000;
        end else if (ce) begin
            stb_reg     <= stb_next;
            ret_data    <= ret_data_next;
            byte_parity <= par_next;
            byte_enable <= be_next;
            err_cnt_reg <= err_cnt_next;
        end
    end

    assign io_read_strobe             = stb_reg[0];
    assign io_write_strobe            = stb_reg[1];
    assign ctrl_cache_copy_wr_strobe  = stb_reg[2];
    assign ctrl_return_valid          = stb_reg[3];
    assign flush_strobe               = stb_reg[4];
    assign purge_strobe               = stb_reg[5];
    assign purge_alloc_strobe         = stb_reg[6];
    assign sync_strobe                = stb_reg[7];
    assign coherent_strobe            = stb_reg[8];
    assign byte_swap_strobe           = stb_reg[9];
    assign zero_len_strobe            = stb_reg[10];
    assign private_strobe             = stb_reg[11];
    assign mem_read_strobe            = stb_reg[12];
    assign dep_space_line_read_strobe = stb_reg[13];
    assign ctrl_mastered              = stb_reg[14];
    assign error_strobe               = stb_reg[15];
    assign mem_oor_strobe             = stb_reg[16];

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic oor_now;
    assign oor_now = av_only & ibtd_pkg::ibtd_is_mem(tt) & ~pdh & (addr >= {mem_limit_reg, 8'h00});

    sequence s_oor_txn;
        ce && oor_now ##1 ce && go;
    endsequence

    property p_io_rd;
        @(posedge mclk) disable iff (!rstn)
        ce && av_only && tt == ibtd_pkg::TT_IO_READ |=> io_read_strobe && !io_write_strobe;
    endproperty
    a_io_rd: assert property (p_io_rd) else $error("io read strobe missing");

    property p_io_wr;
        @(posedge mclk) disable iff (!rstn)
        ce && av_only && tt == ibtd_pkg::TT_IO_WRITE |=> io_write_strobe && !io_read_strobe;
    endproperty
    a_io_wr: assert property (p_io_wr) else $error("io write strobe missing");

    property p_flush;
        @(posedge mclk) disable iff (!rstn)
        ce && av_only && tt == ibtd_pkg::TT_FLUSH |=> flush_strobe && !purge_strobe;
    endproperty
    a_flush: assert property (p_flush) else $error("flush strobe missing");

    property p_mastered;
        @(posedge mclk) disable iff (!rstn)
        ce && av_only && in_master_id == ioc_id |=> ctrl_mastered;
    endproperty
    a_mastered: assert property (p_mastered) else $error("mastered flag missing");

    property p_c2c;
        @(posedge mclk) disable iff (!rstn)
        $past(ce) && ctrl_cache_copy_wr_strobe
        |-> $past(in_master_id == ioc_id && tt == ibtd_pkg::TT_C2C_WRITE);
    endproperty
    a_c2c: assert property (p_c2c) else $error("copy write with foreign id");

    property p_path;
        @(posedge mclk) disable iff (!rstn)
        ce && go && path_err && in_master_id == ioc_id
        |=> ctrl_return_valid && byte_parity == 16'hffff;
    endproperty
    a_path: assert property (p_path) else $error("path error not flagged");

    property p_coh;
        @(posedge mclk) disable iff (!rstn)
        $past(ce) |-> coherent_strobe == $past(go && in_addr_valid && !in_data_valid && tt[2]);
    endproperty
    a_coh: assert property (p_coh) else $error("coherent strobe wrong");

    property p_err_late;
        @(posedge mclk) disable iff (!rstn)
        s_oor_txn |=> error_strobe && mem_oor_strobe;
    endproperty
    a_err_late: assert property (p_err_late) else $error("late error missing");

    property p_oor_err;
        @(posedge mclk) disable iff (!rstn)
        mem_oor_strobe |-> error_strobe;
    endproperty
    a_oor_err: assert property (p_oor_err) else $error("range error without error");

    property p_be;
        @(posedge mclk) disable iff (!rstn)
        $past(ce) && (io_read_strobe || io_write_strobe) |-> byte_enable == $past(in_byte_enable);
    endproperty
    a_be: assert property (p_be) else $error("byte enables not aligned");

    property p_memrd;
        @(posedge mclk) disable iff (!rstn)
        dep_space_line_read_strobe || zero_len_strobe |-> !mem_read_strobe;
    endproperty
    a_memrd: assert property (p_memrd) else $error("memory read overlap");

    property p_srst;
        @(posedge mclk) disable iff (!rstn)
        ce && srst |=> !io_read_strobe && !coherent_strobe && !error_strobe && !ctrl_return_valid;
    endproperty
    a_srst: assert property (p_srst) else $error("strobe during sync reset");

endmodule // ibtd_top

// file: tb/ibtd_ioc_model.sv
// i/o controller model: tallies coherent transactions that it mastered
// assumes decoder strobes are registered on mclk
module ibtd_ioc_model (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       coherent_strobe,
    input  wire logic       ctrl_mastered,
    output logic      [7:0] own_coh_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) own_coh_cnt <= '0;
        else if (coherent_strobe && ctrl_mastered) own_coh_cnt <= own_coh_cnt + 8'h01;
    end
endmodule // ibtd_ioc_model

// file: tb/test_ibtd_top.sv
// self-checking bench for the input bus transaction decoder
// assumes ibtd_top, ibtd_pkg and the i/o controller model are compiled first
module test_ibtd_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic         mclk = '0, rstn = '0, ce = 1'h1, srst = '0, err;
    logic         psel = '0, penable = '0, pwrite = '0, pready, pslverr;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0, prdata, rd;
    logic         in_addr_valid = '0, in_data_valid = '0, in_addr_parity = '0;
    logic         in_ctrl_parity = '0;
    logic [4:0]   bus_txn_type = '0;
    logic [2:0]   in_master_id = '0;
    logic [127:0] in_addr_data = '0, ret_data;
    logic [15:0]  in_byte_enable = '0, byte_parity, byte_enable;
    logic         io_read_strobe, io_write_strobe, ctrl_cache_copy_wr_strobe;
    logic         ctrl_return_valid, flush_strobe, purge_strobe, purge_alloc_strobe;
    logic         sync_strobe, coherent_strobe, byte_swap_strobe, zero_len_strobe;
    logic         private_strobe, mem_read_strobe, dep_space_line_read_strobe;
    logic         ctrl_mastered, error_strobe, mem_oor_strobe;
    logic [7:0]   own_coh_cnt;
    int           mismatches = 0, tests_run = 0;
    localparam logic [39:0]  A_IO = 40'hf0_0000_1000, A_MEM = 40'h00_0000_1000;
    localparam logic [39:0]  A_DEP = 40'hf0_0000_0000, A_OOR = 40'h02_0000_0000;
    localparam logic [127:0] D = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    ////////////////////////////////////////////////////////////////////////////////
    ibtd_top ibtd_top_i (.*);
    ibtd_ioc_model ibtd_ioc_model_i (.mclk(mclk), .rstn(rstn),
        .coherent_strobe(coherent_strobe), .ctrl_mastered(ctrl_mastered),
        .own_coh_cnt(own_coh_cnt));
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [15:0] bpar(input logic [127:0] d);
        logic [15:0] p;
        for (int i = 0; i < 16; i++) p[i] = ^d[8*i+:8];
        return p;
    endfunction
    // one address cycle, strobes one edge later, errors two edges later
    task automatic txn(input logic [4:0] t, input logic [2:0] id, input logic [39:0] a,
                       input logic bad, input logic [15:0] be, input logic [15:0] e);
        @(posedge mclk);
        {in_addr_valid, in_data_valid, bus_txn_type, in_master_id} <= {2'h2, t, id};
        in_addr_data <= {64'h0, a[7:0], a[15:8], a[23:16], a[31:24], a[39:32], 24'h0};
        in_addr_parity <= (^a) ^ bad;
        in_ctrl_parity <= ^{t, id};
        in_byte_enable <= be;
        @(posedge mclk);
        in_addr_valid <= 1'h0;
        @(negedge mclk);
        check({io_read_strobe, io_write_strobe, ctrl_cache_copy_wr_strobe, flush_strobe,
               purge_strobe, purge_alloc_strobe, sync_strobe, coherent_strobe,
               byte_swap_strobe, zero_len_strobe, private_strobe, mem_read_strobe,
               dep_space_line_read_strobe, ctrl_mastered}, e[15:2]);
        check(byte_enable, (e[15] | e[14]) ? be : 16'h0);
        @(negedge mclk);
        check({error_strobe, mem_oor_strobe}, e[1:0]);
    endtask
    task automatic dat(input logic [2:0] id, input logic av, input logic rv,
                       input logic [15:0] bp);
        @(posedge mclk);
        {in_addr_valid, in_data_valid, in_master_id} <= {av, 1'h1, id};
        in_addr_data <= D;
        @(posedge mclk);
        {in_addr_valid, in_data_valid} <= 2'h0;
        @(negedge mclk);
        check({ctrl_return_valid, byte_parity}, {rv, bp});
        check(ret_data, D);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, wd};
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        d = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'h1;
        apb(1'h0, ibtd_pkg::OFS_CTRL, 32'h0, rd, err);
        check({err, rd}, {1'h0, ibtd_pkg::CTRL_RST});
        txn(ibtd_pkg::TT_IO_READ, 3'h4, A_IO, 1'h0, 16'ha5a5, 16'h8004);
        txn(ibtd_pkg::TT_IO_WRITE, 3'h4, A_IO, 1'h0, 16'h5a5a, 16'h4004);
        txn(ibtd_pkg::TT_C2C_WRITE, 3'h4, A_MEM, 1'h0, 16'h00ff, 16'h2004);
        txn(ibtd_pkg::TT_C2C_WRITE, 3'h1, A_MEM, 1'h0, 16'h00ff, 16'h0000);
        txn(ibtd_pkg::TT_FLUSH, 3'h4, A_MEM, 1'h0, 16'h0, 16'h1104);
        txn(ibtd_pkg::TT_PURGE, 3'h4, A_MEM, 1'h0, 16'h0, 16'h0904);
        txn(ibtd_pkg::TT_PURGE_ALLOC, 3'h4, A_MEM, 1'h0, 16'h0, 16'h0504);
        txn(ibtd_pkg::TT_SYNC, 3'h4, A_MEM, 1'h0, 16'h0, 16'h0304);
        txn(ibtd_pkg::TT_READ_BS, 3'h1, A_MEM, 1'h0, 16'h0, 16'h0090);
        txn(ibtd_pkg::TT_READ_PRIV_0LN, 3'h1, A_MEM, 1'h0, 16'h0, 16'h0160);
        txn(ibtd_pkg::TT_READ_PRIV, 3'h1, A_MEM, 1'h0, 16'h0, 16'h0130);
        txn(ibtd_pkg::TT_READ, 3'h1, A_DEP, 1'h0, 16'h0, 16'h0008);
        txn(ibtd_pkg::TT_IO_READ, 3'h1, A_MEM, 1'h0, 16'h0, 16'h8002);
        txn(ibtd_pkg::TT_READ_PRIV, 3'h1, A_OOR, 1'h0, 16'h0, 16'h0133);
        txn(ibtd_pkg::TT_READ, 3'h1, A_MEM, 1'h1, 16'h0, 16'h0012);
        txn(ibtd_pkg::TT_BCAST_ERR, 3'h1, A_MEM, 1'h0, 16'h0, 16'h0002);
        apb(1'h0, ibtd_pkg::OFS_STATUS, 32'h0, rd, err);
        check({rd[31:16], rd[3:0]}, {16'h0004, 4'h1});
        check(own_coh_cnt, 8'h04);
        dat(3'h4, 1'h0, 1'h1, bpar(D));
        dat(3'h4, 1'h1, 1'h1, 16'hffff);
        dat(3'h1, 1'h0, 1'h0, bpar(D));
        @(posedge mclk);
        srst <= 1'h1;
        txn(ibtd_pkg::TT_IO_READ, 3'h4, A_IO, 1'h0, 16'h0, 16'h0000);
        @(posedge mclk);
        srst <= 1'h0;
        apb(1'h1, ibtd_pkg::OFS_CTRL, 32'h0000_0040, rd, err);
        txn(ibtd_pkg::TT_FLUSH, 3'h4, A_MEM, 1'h0, 16'h0, 16'h0000);
        apb(1'h1, ibtd_pkg::OFS_CTRL, ibtd_pkg::CTRL_RST, rd, err);
        apb(1'h0, 12'h010, 32'h0, rd, err);
        check({err, rd}, {1'h1, 32'h0});
        print_verdict();
    end
    initial begin
        #100us;
        mismatches++;
        print_verdict();
    end
endmodule // test_ibtd_top
